// ### tb/sfsec_assertions.sv
// pin level assertions for the flash id and security register block
`default_nettype none
module sfsec_assertions #(
    parameter logic [19:0] ERASE_CYCLES = 20'h04E20,
    parameter logic [19:0] PROG_CYCLES  = 20'h01388
) (
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       cs_n_i,
    input wire logic       sclk_i,
    input wire logic       latch_set_i,
    input wire logic [3:0] io_oe_o,
    input wire logic       write_enable_latch_o,
    input wire logic       busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] busy_cnt_reg;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // at the falling edge of busy the count holds the whole run length
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !busy_o) begin
            busy_cnt_reg <= 20'h00000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 20'h00001;
        end
    end
    sequence s_busy_end;
        $fell(busy_o);
    endsequence
    sequence s_erase_end;
        s_busy_end ##0 (busy_cnt_reg == ERASE_CYCLES);
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n_i |=>
        io_oe_o == 4'h0 && !busy_o && !write_enable_latch_o)
        else $error("outputs not quiet after reset");
    oe_release_a: assert property (cs_n_i |=> io_oe_o == 4'h0)
        else $error("data lines driven after deselect");
    oe_code_a: assert property (
        io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("illegal output enable pattern");
    out_on_fall_a: assert property ($rose(|io_oe_o) |->
        !$past(sclk_i) && $past(sclk_i, 2))
        else $error("output started off a clock fall");
    busy_len_a: assert property (s_busy_end |->
        busy_cnt_reg == ERASE_CYCLES || busy_cnt_reg == PROG_CYCLES)
        else $error("busy run has wrong length");
    latch_clear_a: assert property (s_erase_end |->
        !write_enable_latch_o)
        else $error("latch still set after erase");
    latch_fall_a: assert property ($fell(write_enable_latch_o) |->
        s_busy_end)
        else $error("latch dropped outside a cycle end");
    busy_start_a: assert property ($rose(busy_o) |->
        $past(cs_n_i) && $past(write_enable_latch_o))
        else $error("busy rose without deselect and latch");
    latch_set_a: assert property (latch_set_i && !busy_o |=>
        write_enable_latch_o)
        else $error("latch not set by set pulse");
endmodule
`default_nettype wire

// ### tb/sfsec_host.sv
// spi host model that frames commands for the flash block
`default_nettype none
module sfsec_host (
    input  wire logic       mclk_i,
    input  wire logic [3:0] io_i,
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic      [3:0] io_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        io_o   = 4'h0;
    end
    ////////////////////////////////////////
    // serial clock idles low and stands still between frames
    task automatic start;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
    endtask
    // no rising clock edge after the last bit; select held low till here
    task automatic stop;
        @(posedge mclk_i);
        sclk_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        io_o   <= ~io_o;
        repeat (2) @(posedge mclk_i);
    endtask
    // unused lanes toggle so a released line never looks settled
    task automatic shift(input logic [63:0] tx, input int n,
                         input int lns, output logic [63:0] rx);
        logic [3:0] msk;
        msk = 4'((1 << lns) - 1);
        rx  = 64'h0;
        for (int k = 0; k < n; k++) begin
            @(posedge mclk_i);
            sclk_o <= 1'b0;
            io_o   <= (4'(tx >> ((n - 1 - k) * lns)) & msk)
                      | (~msk & {4{k[0]}});
            repeat (2) @(posedge mclk_i);
            rx = (rx << lns) | 64'(lns == 1 ? {3'h0, io_i[1]} : io_i & msk);
            sclk_o <= 1'b1;
            repeat (2) @(posedge mclk_i);
        end
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the flash id and security register block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] ERASE_N = 20'h0012C;
    localparam logic [19:0] PROG_N  = 20'h00004;
    // id values are arbitrary
    localparam logic [7:0]  MFR  = 8'hC3;
    localparam logic [7:0]  DEV  = 8'h21;
    localparam logic [7:0]  MTYP = 8'h7E;
    localparam logic [7:0]  CAP  = 8'h4D;
    localparam logic [63:0] UID  = 64'hFEDCBA9876543210;
    logic        mclk, rst_n, latch_set;
    logic [3:0]  lock;
    logic [63:0] rx;
    wire logic   cs_n, sclk, latch, busy;
    wire logic [3:0] h_io, io_w, dut_io, dut_oe;
    // counts cycles with any data line driven by the block
    int          error_cnt, total_checks, cyc, oe_cnt, oe_mark;
    sfsec_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MTYP), .CAPACITY(CAP),
        .UNIQUE_ID(UID), .ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) u_dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
        .io_i(io_w), .io_o(dut_io), .io_oe_o(dut_oe), .latch_set_i(latch_set),
        .security_lock_bits_i(lock), .write_enable_latch_o(latch),
        .busy_o(busy));
    sfsec_host u_host (.mclk_i(mclk), .io_i(io_w), .cs_n_o(cs_n),
        .sclk_o(sclk), .io_o(h_io));
    assign io_w = (dut_oe & dut_io) | (~dut_oe & h_io);
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (dut_oe !== 4'h0) oe_cnt <= oe_cnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("ERROR %0t run did not finish", $time);
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // opcode, lead-in clocks on pl lanes, then rn answer clocks on rl lanes
    task automatic cmd(input logic [7:0] op, input logic [63:0] pre,
                       input int pn, input int pl, input int rn,
                       input int rl);
        u_host.start();
        u_host.shift({56'h0, op}, 8, 1, rx);
        if (pn > 0) u_host.shift(pre, pn, pl, rx);
        if (rn > 0) u_host.shift(64'h0, rn, rl, rx);
        u_host.stop();
    endtask
    task automatic latch_pulse;
        @(posedge mclk);
        latch_set <= 1'b1;
        @(posedge mclk);
        latch_set <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
        chk(64'(busy), 64'h0);
    endtask
    ////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        latch_set = 1'b0;
        lock = 4'h0;
        error_cnt = 0;
        total_checks = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        cmd(sfsec_pkg::OP_JEDEC, 64'h0, 0, 1, 48, 1);
        chk(rx, {16'h0, MFR, MTYP, CAP, MFR, MTYP, CAP});
        cmd(sfsec_pkg::OP_MDID, 64'h0, 24, 1, 32, 1);
        chk(rx, {32'h0, MFR, DEV, MFR, DEV});
        cmd(sfsec_pkg::OP_MDID2, 64'hF0, 16, 2, 16, 2);
        chk(rx, {32'h0, MFR, DEV, MFR, DEV});
        cmd(sfsec_pkg::OP_MDID4, 64'hF00000, 12, 4, 8, 4);
        chk(rx, {32'h0, MFR, DEV, MFR, DEV});
        cmd(sfsec_pkg::OP_UID, 64'h0, 32, 1, 64, 1);
        chk(rx, UID);
        // registers 2 and 3 are used, register 0 is left alone
        cmd(sfsec_pkg::OP_SERASE, 64'h003000, 24, 1, 0, 1);
        chk(64'(busy), 64'h0);
        latch_pulse();
        chk(64'(latch), 64'h1);
        cmd(sfsec_pkg::OP_SERASE, 64'h0020, 16, 1, 0, 1);
        chk(64'(busy), 64'h0);
        cmd(sfsec_pkg::OP_SERASE, 64'h004000, 24, 1, 0, 1);
        chk(64'(busy), 64'h0);
        cmd(sfsec_pkg::OP_SERASE, 64'h002000, 24, 1, 0, 1);
        chk(64'(busy), 64'h1);
        wait_idle();
        chk(64'(latch), 64'h0);
        latch_pulse();
        cmd(sfsec_pkg::OP_SPROG, 64'h0020FEA53C0F, 48, 1, 0, 1);
        wait_idle();
        cmd(sfsec_pkg::OP_SREAD, 64'h0020FE00, 32, 1, 32, 1);
        chk(rx, 64'hA53C0FFF);
        lock <= 4'h4;
        latch_pulse();
        cmd(sfsec_pkg::OP_SERASE, 64'h002000, 24, 1, 0, 1);
        chk(64'(busy), 64'h0);
        cmd(sfsec_pkg::OP_SPROG, 64'h00200000, 32, 1, 0, 1);
        chk(64'(busy), 64'h0);
        cmd(sfsec_pkg::OP_SREAD, 64'h0020FF00, 32, 1, 16, 1);
        chk(rx, 64'h3C0F);
        cmd(sfsec_pkg::OP_SERASE, 64'h003000, 24, 1, 0, 1);
        oe_mark = oe_cnt;
        cmd(sfsec_pkg::OP_SREAD, 64'h00300000, 32, 1, 8, 1);
        chk(64'(oe_cnt - oe_mark), 64'h0);
        chk(64'(busy), 64'h1);
        wait_idle();
        cmd(sfsec_pkg::OP_SREAD, 64'h00301000, 32, 1, 8, 1);
        chk(rx, 64'hFF);
        give_verdict();
    end
endmodule
bind sfsec_top sfsec_assertions #(.ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)) u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .latch_set_i(latch_set_i),
    .io_oe_o(io_oe_o), .write_enable_latch_o(write_enable_latch_o),
    .busy_o(busy_o));
`default_nettype wire

// ### verilog/sfsec_pkg.sv
// constants and types for the flash identification and security register block
`default_nettype none
package sfsec_pkg;
    // opcodes
    localparam logic [7:0] OP_MDID    = 8'h90;
    localparam logic [7:0] OP_MDID2   = 8'h92;
    localparam logic [7:0] OP_MDID4   = 8'h94;
    localparam logic [7:0] OP_UID     = 8'h4B;
    localparam logic [7:0] OP_JEDEC   = 8'h9F;
    localparam logic [7:0] OP_SERASE  = 8'h44;
    localparam logic [7:0] OP_SPROG   = 8'h42;
    localparam logic [7:0] OP_SREAD   = 8'h48;
    // serial clocks between opcode and first output bit or data byte
    localparam logic [5:0] PRE_NONE   = 6'h00;
    localparam logic [5:0] PRE_ADDR   = 6'h18;
    localparam logic [5:0] PRE_DUAL   = 6'h10;
    localparam logic [5:0] PRE_QUAD   = 6'h0C;
    localparam logic [5:0] PRE_LONG   = 6'h20;
    // lanes per serial clock
    localparam logic [3:0] LANE1      = 4'h1;
    localparam logic [3:0] LANE2      = 4'h2;
    localparam logic [3:0] LANE4      = 4'h4;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [5:0] OPC_LAST   = 6'h07;
    localparam logic [3:0] OE_SINGLE  = 4'h2;
    localparam logic [3:0] OE_DUAL    = 4'h3;
    localparam logic [3:0] OE_QUAD    = 4'hF;
    // last byte index of each repeating id sequence
    localparam logic [2:0] MDID_LAST  = 3'h1;
    localparam logic [2:0] JEDEC_LAST = 3'h2;
    localparam logic [2:0] UID_LAST   = 3'h7;
    // security register address fields
    localparam logic [7:0] SEC_HI     = 8'h00;
    localparam logic [3:0] SEC_MAX    = 4'h3;
    localparam logic [3:0] SEC_MID    = 4'h0;
    localparam logic [7:0] ERASED     = 8'hFF;
    localparam logic [19:0] SEC_BYTES = 20'h00100;
    typedef enum logic [2:0] {
        ST_CMD,
        ST_PRE,
        ST_OUT,
        ST_DIN,
        ST_HOLD,
        ST_IGN
    } sfsec_state_t;
endpackage
`default_nettype wire

// ### verilog/sfsec_top.sv
// serial flash id reads and security register erase, program and read
// How it works
// - 90h plus zero address returns maker then device byte, msb first
// - id reads keep cycling through their bytes until chip select rises
// - 92h takes address and mode byte two bits a clock, answers likewise
// - 94h takes address and mode four bits a clock, four dummies
// - 4Bh after four dummy bytes shifts out the fixed 64-bit number
// - 9Fh returns maker, memory type and capacity bytes, msb first
// - address 00h, index 0-3 in bits 15-12, zero 11-8, byte offset
// - erase 44h is taken only with the write enable latch set
// - erase runs self-timed with busy high, then busy drops
// - finished erase clears the write enable latch
// - lock bit set makes erase and program of that register ignored
// - 42h with latch set programs 1 to 256 bytes into erased cells
// - 48h takes address and eight dummies, then data msb first
// - read offset increments per byte, wrapping FFh to 00h
// - security read while busy is ignored, cycle undisturbed
`default_nettype none
module sfsec_top #(
    parameter logic [7:0]  MFR_ID       = 8'h5A, // arbitrary value
    parameter logic [7:0]  DEV_ID       = 8'h13, // arbitrary value
    parameter logic [7:0]  MEM_TYPE     = 8'h60, // arbitrary value
    parameter logic [7:0]  CAPACITY     = 8'h14, // arbitrary value
    parameter logic [63:0] UNIQUE_ID    = 64'h0123456789ABCDEF, // arbitrary
    parameter logic [19:0] ERASE_CYCLES = 20'h04E20,
    parameter logic [19:0] PROG_CYCLES  = 20'h01388
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic [3:0] io_i,
    output logic      [3:0] io_o,
    output logic      [3:0] io_oe_o,
    input  wire logic       latch_set_i,
    input  wire logic [3:0] security_lock_bits_i,
    output logic            write_enable_latch_o,
    output logic            busy_o
);

typedef struct packed {
    sfsec_pkg::sfsec_state_t state;
    logic        sclk_d;
    logic [7:0]  cmd;
    logic [5:0]  cnt;
    logic [31:0] sh;
    logic [1:0]  sel;
    logic [7:0]  off;
    logic [7:0]  obyte;
    logic [3:0]  obit;
    logic [2:0]  idx;
    logic [3:0]  io;
    logic [3:0]  oe;
    logic        prog_any;
    logic        latch;
    logic        busy;
    logic        erasing;
    logic [1:0]  esel;
    logic [19:0] timer;
} sfsec_st_t;

sfsec_st_t  st_reg;
sfsec_st_t  st_next;
logic [7:0] mem [0:1023];
logic       mem_we;
logic [9:0] mem_wa;
logic [7:0] mem_wd;

////////////////////////////////////////////////////////////////////////////
function automatic logic [5:0] pre_clk(input logic [7:0] c);
    case (c)
        sfsec_pkg::OP_MDID:   pre_clk = sfsec_pkg::PRE_ADDR;
        sfsec_pkg::OP_MDID2:  pre_clk = sfsec_pkg::PRE_DUAL;
        sfsec_pkg::OP_MDID4:  pre_clk = sfsec_pkg::PRE_QUAD;
        sfsec_pkg::OP_UID:    pre_clk = sfsec_pkg::PRE_LONG;
        sfsec_pkg::OP_SREAD:  pre_clk = sfsec_pkg::PRE_LONG;
        sfsec_pkg::OP_SERASE: pre_clk = sfsec_pkg::PRE_ADDR;
        sfsec_pkg::OP_SPROG:  pre_clk = sfsec_pkg::PRE_ADDR;
        default:              pre_clk = sfsec_pkg::PRE_NONE;
    endcase
endfunction

function automatic logic known(input logic [7:0] c);
    known = (pre_clk(c) != sfsec_pkg::PRE_NONE) ||
            (c == sfsec_pkg::OP_JEDEC);
endfunction

function automatic logic [3:0] lanes(input logic [7:0] c);
    case (c)
        sfsec_pkg::OP_MDID2: lanes = sfsec_pkg::LANE2;
        sfsec_pkg::OP_MDID4: lanes = sfsec_pkg::LANE4;
        default:             lanes = sfsec_pkg::LANE1;
    endcase
endfunction

function automatic logic [31:0] shift_in(input logic [31:0] s,
                                         input logic [3:0]  w,
                                         input logic [3:0]  d);
    case (w)
        sfsec_pkg::LANE2: shift_in = {s[29:0], d[1:0]};
        sfsec_pkg::LANE4: shift_in = {s[27:0], d};
        default:          shift_in = {s[30:0], d[0]};
    endcase
endfunction

function automatic logic [7:0] id_byte(input logic [7:0] c,
                                       input logic [2:0] i);
    logic [63:0] t;
    t = UNIQUE_ID >> {3'(sfsec_pkg::UID_LAST - i), 3'b000};
    case (c)
        sfsec_pkg::OP_JEDEC: begin
            case (i)
                3'h0:    id_byte = MFR_ID;
                3'h1:    id_byte = MEM_TYPE;
                default: id_byte = CAPACITY;
            endcase
        end
        sfsec_pkg::OP_UID: id_byte = t[7:0];
        default: id_byte = i[0] ? DEV_ID : MFR_ID;
    endcase
endfunction

function automatic logic [2:0] id_last(input logic [7:0] c);
    case (c)
        sfsec_pkg::OP_JEDEC: id_last = sfsec_pkg::JEDEC_LAST;
        sfsec_pkg::OP_UID:   id_last = sfsec_pkg::UID_LAST;
        default:             id_last = sfsec_pkg::MDID_LAST;
    endcase
endfunction

function automatic logic addr_ok(input logic [23:0] a);
    addr_ok = (a[23:16] == sfsec_pkg::SEC_HI) &&
              (a[15:12] <= sfsec_pkg::SEC_MAX) &&
              (a[11:8] == sfsec_pkg::SEC_MID);
endfunction

////////////////////////////////////////////////////////////////////////////
always_comb begin
    logic        rise;
    logic        fall;
    logic [31:0] shv;
    logic [23:0] a;
    logic [7:0]  opc;
    logic [7:0]  noff;
    logic [2:0]  nidx;
    logic [3:0]  w;
    rise = 1'b0;
    fall = 1'b0;
    shv = '0;
    a = '0;
    opc = '0;
    noff = '0;
    nidx = '0;
    w = '0;
    st_next = st_reg;
    st_next.sclk_d = sclk_i;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    rise = sclk_i & ~st_reg.sclk_d & ~cs_n_i;
    fall = ~sclk_i & st_reg.sclk_d & ~cs_n_i;

    // self-timed cycle; erase wipes the register in its last 256 cycles
    if (latch_set_i && !st_reg.busy) begin
        st_next.latch = 1'b1;
    end
    if (st_reg.busy) begin
        if (st_reg.erasing && st_reg.timer < sfsec_pkg::SEC_BYTES) begin
            mem_we = 1'b1;
            mem_wa = {st_reg.esel, st_reg.timer[7:0]};
            mem_wd = sfsec_pkg::ERASED;
        end
        if (st_reg.timer == '0) begin
            st_next.busy = 1'b0;
            st_next.erasing = 1'b0;
            st_next.latch = 1'b0;
        end else begin
            st_next.timer = st_reg.timer - 20'h00001;
        end
    end

    if (cs_n_i) begin
        // erase only when select rose right after the last address bit
        if (st_reg.state == sfsec_pkg::ST_HOLD) begin
            st_next.busy = 1'b1;
            st_next.erasing = 1'b1;
            st_next.esel = st_reg.sel;
            st_next.timer = ERASE_CYCLES - 20'h00001;
        end
        if (st_reg.state == sfsec_pkg::ST_DIN && st_reg.prog_any) begin
            st_next.busy = 1'b1;
            st_next.timer = PROG_CYCLES - 20'h00001;
        end
        st_next.state = sfsec_pkg::ST_CMD;
        st_next.cnt = '0;
        st_next.oe = '0;
        st_next.io = '0;
        st_next.prog_any = 1'b0;
    end else if (rise) begin
        case (st_reg.state)
            sfsec_pkg::ST_CMD: begin
                st_next.sh = shift_in(st_reg.sh, sfsec_pkg::LANE1, io_i);
                st_next.cnt = st_reg.cnt + 6'h01;
                if (st_reg.cnt == sfsec_pkg::OPC_LAST) begin
                    opc = st_next.sh[7:0];
                    st_next.cmd = opc;
                    st_next.cnt = '0;
                    st_next.idx = '0;
                    if (!known(opc)) begin
                        st_next.state = sfsec_pkg::ST_IGN;
                    end else if (opc == sfsec_pkg::OP_SREAD &&
                                 st_reg.busy) begin
                        st_next.state = sfsec_pkg::ST_IGN;
                    end else if ((opc == sfsec_pkg::OP_SERASE ||
                                  opc == sfsec_pkg::OP_SPROG) &&
                                 (!st_reg.latch || st_reg.busy)) begin
                        st_next.state = sfsec_pkg::ST_IGN;
                    end else if (pre_clk(opc) == sfsec_pkg::PRE_NONE) begin
                        st_next.state = sfsec_pkg::ST_OUT;
                        st_next.obyte = id_byte(opc, '0);
                        st_next.obit = sfsec_pkg::BYTE_BITS;
                    end else begin
                        st_next.state = sfsec_pkg::ST_PRE;
                    end
                end
            end
            sfsec_pkg::ST_PRE: begin
                shv = shift_in(st_reg.sh, lanes(st_reg.cmd), io_i);
                st_next.sh = shv;
                st_next.cnt = st_reg.cnt + 6'h01;
                if (st_next.cnt == pre_clk(st_reg.cmd)) begin
                    st_next.cnt = '0;
                    a = (st_reg.cmd == sfsec_pkg::OP_SREAD) ?
                        shv[31:8] : shv[23:0];
                    st_next.sel = a[13:12];
                    st_next.off = a[7:0];
                    st_next.obit = sfsec_pkg::BYTE_BITS;
                    st_next.state = sfsec_pkg::ST_OUT;
                    st_next.obyte = id_byte(st_reg.cmd, '0);
                    case (st_reg.cmd)
                        sfsec_pkg::OP_SREAD: begin
                            st_next.obyte = mem[{a[13:12], a[7:0]}];
                            if (!addr_ok(a)) begin
                                st_next.state = sfsec_pkg::ST_IGN;
                            end
                        end
                        sfsec_pkg::OP_SERASE,
                        sfsec_pkg::OP_SPROG: begin
                            st_next.state =
                                (st_reg.cmd == sfsec_pkg::OP_SERASE) ?
                                sfsec_pkg::ST_HOLD : sfsec_pkg::ST_DIN;
                            if (!addr_ok(a) ||
                                security_lock_bits_i[a[13:12]]) begin
                                st_next.state = sfsec_pkg::ST_IGN;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            sfsec_pkg::ST_DIN: begin
                shv = shift_in(st_reg.sh, sfsec_pkg::LANE1, io_i);
                st_next.sh = shv;
                st_next.cnt = st_reg.cnt + 6'h01;
                if (st_reg.cnt == sfsec_pkg::OPC_LAST) begin
                    // programming only clears bits: and into the cell
                    mem_we = 1'b1;
                    mem_wa = {st_reg.sel, st_reg.off};
                    mem_wd = mem[{st_reg.sel, st_reg.off}] & shv[7:0];
                    st_next.off = st_reg.off + 8'h01;
                    st_next.cnt = '0;
                    st_next.prog_any = 1'b1;
                end
            end
            sfsec_pkg::ST_HOLD: st_next.state = sfsec_pkg::ST_IGN;
            default: ;
        endcase
    end else if (fall && st_reg.state == sfsec_pkg::ST_OUT) begin
        w = lanes(st_reg.cmd);
        case (w)
            sfsec_pkg::LANE2: begin
                st_next.io = {2'b00, st_reg.obyte[7:6]};
                st_next.oe = sfsec_pkg::OE_DUAL;
            end
            sfsec_pkg::LANE4: begin
                st_next.io = st_reg.obyte[7:4];
                st_next.oe = sfsec_pkg::OE_QUAD;
            end
            default: begin
                st_next.io = {2'b00, st_reg.obyte[7], 1'b0};
                st_next.oe = sfsec_pkg::OE_SINGLE;
            end
        endcase
        st_next.obyte = st_reg.obyte << w;
        st_next.obit = st_reg.obit - w;
        if (st_reg.obit == w) begin
            st_next.obit = sfsec_pkg::BYTE_BITS;
            if (st_reg.cmd == sfsec_pkg::OP_SREAD) begin
                noff = st_reg.off + 8'h01;
                st_next.off = noff;
                st_next.obyte = mem[{st_reg.sel, noff}];
            end else begin
                nidx = (st_reg.idx == id_last(st_reg.cmd)) ? 3'h0 :
                       st_reg.idx + 3'h1;
                st_next.idx = nidx;
                st_next.obyte = id_byte(st_reg.cmd, nidx);
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
        st_reg <= '{state: sfsec_pkg::ST_CMD, default: '0};
    end else begin
        st_reg <= st_next;
    end
end

// cells are nonvolatile: reset leaves them alone
always_ff @(posedge mclk_i) begin
    if (mem_we) begin
        mem[mem_wa] <= mem_wd;
    end
end

assign io_o = st_reg.io;
assign io_oe_o = st_reg.oe;
assign write_enable_latch_o = st_reg.latch;
assign busy_o = st_reg.busy;

endmodule
`default_nettype wire
